/* File: bench/cbt_board_model.sv */
`timescale 1ns/100ps

module cbt_board_model (
    // Clock and bench control
    input wire logic clock,
    input wire logic fb_hold,
    input wire logic err_on,
    // Device pins
    input wire logic [1:0] feedback_bank_outputs,
    output logic primary_reference_pair,
    output logic secondary_reference_pair,
    output logic vco_level,
    output logic phase_error,
    output logic feedback_input_pin
);
    logic [3:0] phase = 4'h0;

    // Primary reference at clock/16, secondary reference and VCO at clock/8
    always_ff @(posedge clock) begin
        phase <= phase + 4'h1;
    end
    assign primary_reference_pair = phase[3];
    assign secondary_reference_pair = phase[2];
    assign vco_level = phase[2];
    // Phase detector outcome as the bench commands it
    assign phase_error = err_on;
    // Feedback held low in test mode, or removed on command
    assign feedback_input_pin = fb_hold ? 1'b0 : feedback_bank_outputs[0];
endmodule // cbt_board_model

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`include "cbt_defines.svh"

module tb_top;
    import cbt_pkg::*;

    // -----
    // Signals
    // -----
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_a;
    logic ref_b;
    logic ref_sel = 1'b0;
    logic fb_pin;
    cbt_tri_pin_t [1:0] fbds = 4'h5;
    cbt_tri_pin_t range = 2'h1;
    cbt_tri_pin_t style = 2'h1;
    logic [1:0] dis = 2'h0;
    logic vco;
    logic perr;
    cbt_bank_t bank1;
    cbt_bank_t bank2;
    logic [1:0] fb_out;
    logic [1:0] fb_oe;
    logic lock;
    logic irq;
    logic fb_hold = 1'b0;
    logic err_on = 1'b0;
    logic [31:0] rd;
    logic se;
    int errors = 0;
    int comparisons = 0;

    always #50 clock = ~clock;

    cbt_top uut (
        .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_reference_pair(ref_a), .secondary_reference_pair(ref_b),
        .reference_source_select(ref_sel), .feedback_input_pin(fb_pin),
        .feedback_divide_select(fbds), .vco_range_select(range), .disable_style_select(style),
        .bank_disable_inputs(dis), .vco_level(vco), .phase_error(perr),
        .bank1_outputs(bank1), .bank2_outputs(bank2), .feedback_bank_outputs(fb_out),
        .feedback_bank_oe(fb_oe), .lock_indicator(lock), .irq(irq)
    );

    cbt_board_model board (
        .clock(clock), .fb_hold(fb_hold), .err_on(err_on), .feedback_bank_outputs(fb_out),
        .primary_reference_pair(ref_a), .secondary_reference_pair(ref_b),
        .vco_level(vco), .phase_error(perr), .feedback_input_pin(fb_pin)
    );

    // -----
    // Helpers
    // -----
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic hang(input string what);
        errors++;
        $display("[FAIL] %s expected done seen timeout", what);
        give_verdict();
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang("pready");
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    function automatic cbt_tri_pin_t lvl(input int l);
        return (l == 0) ? 2'h1 : (l == 1) ? 2'h0 : 2'h2;
    endfunction

    function automatic logic pick(input int s);
        return (s == 0) ? fb_pin : (s == 1) ? ref_a : fb_out[0];
    endfunction

    task automatic rises(input int s, input int n);
        int k;
        int c;
        logic p;
        k = 0;
        c = 0;
        p = pick(s);
        while (k < n) begin
            @(posedge clock);
            if (pick(s) && !p) k++;
            p = pick(s);
            c++;
            if (c > 5000) hang("edges");
        end
    endtask

    task automatic wait_lock(input logic v, input int lim, output int fbs);
        int c;
        logic p;
        c = 0;
        fbs = 0;
        p = fb_pin;
        while (lock !== v) begin
            @(posedge clock);
            if (fb_pin && !p) fbs++;
            p = fb_pin;
            c++;
            if (c > lim) hang("lock");
        end
    endtask

    // -----
    // Scenarios
    // -----
    task automatic t_regs();
        apb(1'b0, `CBT_ADDR_WDOG, 32'h0);
        check("wdog reset", rd, 32'h10);
        apb(1'b0, `CBT_ADDR_IRQ_MASK, 32'h0);
        check("mask reset", rd, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        check("unmapped err", 32'(se), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, `CBT_ADDR_WDOG, 32'h120);
        apb(1'b0, `CBT_ADDR_WDOG, 32'h0);
        check("wdog width", rd, 32'h20);
        apb(1'b1, `CBT_ADDR_WDOG, 32'h10);
        $display("test regs done");
    endtask

    task automatic t_lock();
        int n;
        err_on <= 1'b1;
        cycles(20);
        err_on <= 1'b0;
        wait_lock(1'b1, 3000, n);
        check("clean edges", 32'(n >= 32), 32'h1);
        check("lock", 32'(lock), 32'h1);
        apb(1'b0, `CBT_ADDR_IRQ_STAT, 32'h0);
        check("gain stat", rd, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, `CBT_ADDR_IRQ_MASK, 32'h1);
        cycles(1);
        check("irq set", 32'(irq), 32'h1);
        apb(1'b1, `CBT_ADDR_IRQ_STAT, 32'h1);
        cycles(1);
        check("irq clear", 32'(irq), 32'h0);
        rises(0, 1);
        cycles(4);
        err_on <= 1'b1;
        wait_lock(1'b0, 500, n);
        check("error edges", 32'(n >= 4 && n <= 5), 32'h1);
        apb(1'b0, `CBT_ADDR_IRQ_STAT, 32'h0);
        check("loss stat", rd, 32'h2);
        err_on <= 1'b0;
        wait_lock(1'b1, 3000, n);
        fb_hold <= 1'b1;
        cycles(3000);
        check("lock before timeout", 32'(lock), 32'h1);
        wait_lock(1'b0, 3000, n);
        fb_hold <= 1'b0;
        $display("test lock done");
    endtask

    task automatic t_dis();
        dis <= 2'h1;
        cycles(54);
        check("hold oe", 32'(bank1.oe), 32'hF);
        repeat (8) begin
            cycles(1);
            check("hold low", 32'(bank1.q), 32'h0);
        end
        check("bank2 on", 32'(bank2.oe), 32'hF);
        dis <= 2'h0;
        cycles(6);
        style <= lvl(2);
        cycles(6);
        dis <= 2'h1;
        cycles(6);
        check("hiz oe", 32'(bank1.oe), 32'h0);
        dis <= 2'h0;
        cycles(6);
        $display("test disable done");
    endtask

    task automatic t_test();
        apb(1'b1, `CBT_ADDR_IRQ_STAT, 32'hF);
        fb_hold <= 1'b1;
        style <= lvl(1);
        dis <= 2'h1;
        cycles(8);
        apb(1'b0, `CBT_ADDR_IRQ_STAT, 32'h0);
        check("test entered", rd, 32'h8);
        check("disable ignored", 32'(bank1.oe), 32'hF);
        rises(1, 1);
        cycles(6);
        check("ref high", 32'(bank1.q), 32'hF);
        cycles(8);
        check("ref low", 32'(bank1.q), 32'h0);
        apb(1'b1, `CBT_ADDR_IRQ_STAT, 32'h8);
        dis <= 2'h2;
        cycles(6);
        check("all hiz", 32'({bank1.oe, bank2.oe, fb_oe}), 32'h0);
        rises(1, 3);
        apb(1'b0, `CBT_ADDR_IRQ_STAT, 32'h0);
        check("not early", rd, 32'h0);
        rises(1, 3);
        cycles(6);
        apb(1'b0, `CBT_ADDR_IRQ_STAT, 32'h0);
        check("reset reached", rd, 32'h4);
        check("lock cleared", 32'(lock), 32'h0);
        cycles(40);
        check("still hiz", 32'({bank1.oe, bank2.oe, fb_oe}), 32'h0);
        dis <= 2'h0;
        cycles(8);
        check("resumed", 32'({bank1.oe, bank2.oe}), 32'hFF);
        style <= lvl(2);
        fb_hold <= 1'b0;
        cycles(8);
        $display("test mode done");
    endtask

    task automatic t_div();
        int ratios[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
        int n;
        int c;
        logic pf;
        logic pv;
        for (int i = 0; i < 9; i++) begin
            fbds <= {lvl(i / 3), lvl(i % 3)};
            cycles(100);
            rises(2, 1);
            n = 0;
            c = 0;
            do begin
                pf = fb_out[0];
                pv = vco;
                @(posedge clock);
                if (vco && !pv) n++;
                c++;
            end while (!(fb_out[0] && !pf) && c < 200);
            check("divide ratio", 32'(n), 32'(ratios[i]));
        end
        $display("test divide done");
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_lock();
        t_dis();
        t_test();
        t_div();
        give_verdict();
    end
endmodule // tb_top

/* File: hdl/cbt_defines.svh */
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CBT_ADDR_WDOG 8'h00
`define CBT_ADDR_STATUS 8'h04
`define CBT_ADDR_IRQ_STAT 8'h08
`define CBT_ADDR_IRQ_MASK 8'h0C

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CBT_WDOG_RESET 8'h10
`define CBT_IRQ_MASK_RESET 4'h0
`define CBT_REF_DIV_LAST 4'hF
`define CBT_TRESET_LAST 3'h4
`define CBT_LOSE_LAST 2'h3
`define CBT_GAIN_LAST 5'h1F
// Synchroniser reset: straps read low, other pins low
`define CBT_PINS_RESET 16'h0055

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define CBT_IRQ_GAIN 0
`define CBT_IRQ_LOSS 1
`define CBT_IRQ_TRESET 2
`define CBT_IRQ_TEST 3

`endif

/* File: hdl/cbt_pkg.sv */
package cbt_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CBT_LVL_LOW = 2'h0,
        CBT_LVL_MID = 2'h1,
        CBT_LVL_HIGH = 2'h2
    } cbt_level_t;

    // Comparator pair of a three-level pin
    typedef struct packed {
        logic high;
        logic low;
    } cbt_tri_pin_t;

    typedef struct packed {
        logic [3:0] ratio;
        cbt_level_t range;
        cbt_level_t style;
        logic second_ref;
    } cbt_config_t;

    typedef struct packed {
        logic [3:0] q;
        logic [3:0] oe;
    } cbt_bank_t;

    typedef enum logic [2:0] {
        CBT_ST_RUN = 3'h1,
        CBT_ST_WAIT = 3'h2,
        CBT_ST_HOLD = 3'h4
    } cbt_state_t;

endpackage

/* File: hdl/cbt_top.sv */
// Notes on behaviour
// - Middle level on the disable-style select puts the device in factory test mode.
// - Test mode bypasses the PLL; the selected reference level becomes the internal clock.
// - Test mode keeps all functions except the PLL and bank disables.
// - Bank-2 disable high in test mode starts a test reset; outputs go high impedance.
// - After five reference rising edges all state machines are forced to reset state.
// - That reset state is derived from feedback divide and range select settings.
// - Outputs and state machines hold until bank-2 disable drops; then test mode resumes.
// - Reference select low picks primary pair, high picks secondary; open reads low.
// - The two three-level divide selects set the feedback bank divide ratio.
// - Each bank disable controls its bank; low enables, high disables per style; open low.
// - Lock indicator high while locked, low while acquiring.
// - Style high disables banks to high impedance; style low to stopped low.
// - Three-level pins decode high, low, or middle when left open.
// - Divide pairs low-low to high-high give 1,2,3,4,5,6,8,10,12; banks divide by one.
// - Stopped-low bank stops within six output cycles on a falling edge, glitch free.
// - Lock drops after four erroneous feedback cycles; rises after 32 clean ones.
// - Watchdog on divided reference drops lock if feedback disappears.
`timescale 1ns/100ps
`include "cbt_defines.svh"

module cbt_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference and feedback pins
    input wire logic primary_reference_pair,
    input wire logic secondary_reference_pair,
    input wire logic reference_source_select,
    input wire logic feedback_input_pin,
    // Strap and disable pins
    input wire cbt_pkg::cbt_tri_pin_t [1:0] feedback_divide_select,
    input wire cbt_pkg::cbt_tri_pin_t vco_range_select,
    input wire cbt_pkg::cbt_tri_pin_t disable_style_select,
    input wire logic [1:0] bank_disable_inputs,
    // Analog PLL macro
    input wire logic vco_level,
    input wire logic phase_error,
    // Clock outputs
    output cbt_pkg::cbt_bank_t bank1_outputs,
    output cbt_pkg::cbt_bank_t bank2_outputs,
    output logic [1:0] feedback_bank_outputs,
    output logic [1:0] feedback_bank_oe,
    // Status
    output logic lock_indicator,
    output logic irq
);
    import cbt_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic cbt_level_t tri_decode(input cbt_tri_pin_t p);
        if (p.high) begin
            return CBT_LVL_HIGH;
        end else if (p.low) begin
            return CBT_LVL_LOW;
        end
        return CBT_LVL_MID;
    endfunction

    function automatic logic [3:0] ratio_of(input cbt_level_t hi, input cbt_level_t lo);
        case ({hi, lo})
            {CBT_LVL_LOW, CBT_LVL_LOW}: return 4'h1;
            {CBT_LVL_LOW, CBT_LVL_MID}: return 4'h2;
            {CBT_LVL_LOW, CBT_LVL_HIGH}: return 4'h3;
            {CBT_LVL_MID, CBT_LVL_LOW}: return 4'h4;
            {CBT_LVL_MID, CBT_LVL_MID}: return 4'h5;
            {CBT_LVL_MID, CBT_LVL_HIGH}: return 4'h6;
            {CBT_LVL_HIGH, CBT_LVL_LOW}: return 4'h8;
            {CBT_LVL_HIGH, CBT_LVL_MID}: return 4'hA;
            {CBT_LVL_HIGH, CBT_LVL_HIGH}: return 4'hC;
            default: return 4'h1;
        endcase
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [15:0] pins_raw;
    logic [15:0] pins_meta;
    logic [15:0] pins;

    assign pins_raw = {primary_reference_pair, secondary_reference_pair, reference_source_select,
                       feedback_input_pin, bank_disable_inputs, vco_level, phase_error,
                       feedback_divide_select, vco_range_select, disable_style_select};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins_meta <= `CBT_PINS_RESET;
            pins <= `CBT_PINS_RESET;
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end

    logic ref_a, ref_b, ref_sel, fb_pin, vco_lvl, perr;
    logic [1:0] dis;
    cbt_tri_pin_t [1:0] fbds_pin;
    cbt_tri_pin_t fs_pin, style_pin;

    assign {ref_a, ref_b, ref_sel, fb_pin, dis, vco_lvl, perr, fbds_pin, fs_pin, style_pin} = pins;

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    cbt_config_t cfg;
    cbt_config_t next_cfg;
    logic test_mode;

    always_comb begin
        next_cfg.style = tri_decode(style_pin);
        next_cfg.range = tri_decode(fs_pin);
        next_cfg.ratio = ratio_of(tri_decode(fbds_pin[1]), tri_decode(fbds_pin[0]));
        next_cfg.second_ref = ref_sel;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg <= '{ratio: 4'h1, range: CBT_LVL_LOW, style: CBT_LVL_LOW, second_ref: 1'b0};
        end else begin
            cfg <= next_cfg;
        end
    end

    assign test_mode = (cfg.style == CBT_LVL_MID);

    // ----------------------------------------
    // Clock source and edges
    // ----------------------------------------
    logic ref_lvl, src_lvl, src_q, ref_q, fb_q;
    logic src_rise, src_fall, ref_rise, fb_rise;

    assign ref_lvl = cfg.second_ref ? ref_b : ref_a;
    assign src_lvl = test_mode ? ref_lvl : vco_lvl;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_q <= 1'b0;
            ref_q <= 1'b0;
            fb_q <= 1'b0;
        end else begin
            src_q <= src_lvl;
            ref_q <= ref_lvl;
            fb_q <= fb_pin;
        end
    end

    assign src_rise = src_lvl & ~src_q;
    assign src_fall = ~src_lvl & src_q;
    assign ref_rise = ref_lvl & ~ref_q;
    assign fb_rise = fb_pin & ~fb_q;

    // ----------------------------------------
    // Test reset sequencer
    // ----------------------------------------
    cbt_state_t state;
    logic [2:0] edge_cnt;
    logic treset, force_fsm, treset_done;

    assign treset = (state != CBT_ST_RUN);
    assign force_fsm = (state == CBT_ST_HOLD);
    assign treset_done = (state == CBT_ST_WAIT) && dis[1] && ref_rise && (edge_cnt == `CBT_TRESET_LAST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= CBT_ST_RUN;
            edge_cnt <= 3'h0;
        end else begin
            case (state)
                CBT_ST_RUN: begin
                    edge_cnt <= 3'h0;
                    if (test_mode && dis[1]) begin
                        state <= CBT_ST_WAIT;
                    end
                end
                CBT_ST_WAIT: begin
                    if (!dis[1]) begin
                        state <= CBT_ST_RUN;
                    end else if (treset_done) begin
                        state <= CBT_ST_HOLD;
                    end else if (ref_rise) begin
                        edge_cnt <= edge_cnt + 3'h1;
                    end
                end
                CBT_ST_HOLD: begin
                    if (!dis[1]) begin
                        state <= CBT_ST_RUN;
                    end
                end
                default: state <= CBT_ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Feedback divider
    // ----------------------------------------
    logic [3:0] fb_cnt;
    logic [3:0] half;
    logic fb_lvl;

    assign half = (cfg.ratio + 4'h1) >> 1;
    assign fb_lvl = (cfg.ratio == 4'h1) ? src_lvl : (fb_cnt < half);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fb_cnt <= 4'h0;
        end else if (force_fsm) begin
            fb_cnt <= cfg.ratio - 4'h1;
        end else if (src_rise) begin
            fb_cnt <= (fb_cnt >= cfg.ratio - 4'h1) ? 4'h0 : fb_cnt + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            feedback_bank_outputs <= 2'h0;
            feedback_bank_oe <= 2'h0;
        end else begin
            feedback_bank_outputs <= {2{fb_lvl}};
            feedback_bank_oe <= {2{~treset}};
        end
    end

    // ----------------------------------------
    // Output banks
    // ----------------------------------------
    logic [1:0] bank_off, held;
    logic hiz_style;

    assign hiz_style = (cfg.style == CBT_LVL_HIGH);
    assign bank_off = test_mode ? 2'h0 : dis;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (!bank_off[b] || hiz_style) begin
                    held[b] <= 1'b0;
                end else if (src_fall) begin
                    held[b] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bank1_outputs <= '0;
            bank2_outputs <= '0;
        end else begin
            bank1_outputs.q <= {4{src_lvl & ~held[0]}};
            bank2_outputs.q <= {4{src_lvl & ~held[1]}};
            bank1_outputs.oe <= {4{~treset & ~(bank_off[0] & hiz_style)}};
            bank2_outputs.oe <= {4{~treset & ~(bank_off[1] & hiz_style)}};
        end
    end

    // ----------------------------------------
    // Lock detector and watchdog
    // ----------------------------------------
    logic locked, lock_gain, lock_loss;
    logic [1:0] err_run;
    logic [4:0] good_run;
    logic [3:0] ref_div;
    logic [7:0] wd_cnt, wdog_limit;
    logic wd_tick, wd_expired;

    assign wd_tick = ref_rise && (ref_div == `CBT_REF_DIV_LAST);
    assign wd_expired = locked && (wd_cnt >= wdog_limit) && !fb_rise;
    assign lock_gain = !locked && fb_rise && !perr && (good_run == `CBT_GAIN_LAST) && !force_fsm;
    assign lock_loss = locked && !force_fsm &&
                       (wd_expired || (fb_rise && perr && (err_run == `CBT_LOSE_LAST)));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_div <= 4'h0;
            wd_cnt <= 8'h00;
        end else if (force_fsm) begin
            ref_div <= {2'h0, cfg.range};
            wd_cnt <= 8'h00;
        end else begin
            if (ref_rise) begin
                ref_div <= ref_div + 4'h1;
            end
            if (fb_rise || !locked) begin
                wd_cnt <= 8'h00;
            end else if (wd_tick && wd_cnt != 8'hFF) begin
                wd_cnt <= wd_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || force_fsm) begin
            locked <= 1'b0;
            err_run <= 2'h0;
            good_run <= 5'h00;
        end else if (lock_gain) begin
            locked <= 1'b1;
            good_run <= 5'h00;
        end else if (lock_loss) begin
            locked <= 1'b0;
            err_run <= 2'h0;
        end else if (fb_rise) begin
            err_run <= (locked && perr) ? err_run + 2'h1 : 2'h0;
            good_run <= (!locked && !perr) ? good_run + 5'h01 : 5'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lock_indicator <= 1'b0;
        end else begin
            lock_indicator <= locked;
        end
    end

    // ----------------------------------------
    // APB registers and interrupts
    // ----------------------------------------
    logic [3:0] irq_stat, irq_mask, events;
    logic test_q, wr_en, mapped;
    logic [31:0] rd_val;

    assign events = {test_mode & ~test_q, treset_done, lock_loss, lock_gain};
    assign wr_en = psel && penable && pwrite && pready;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            `CBT_ADDR_WDOG: rd_val = {24'h000000, wdog_limit};
            `CBT_ADDR_STATUS: rd_val = {18'h00000, locked, state, test_mode, cfg};
            `CBT_ADDR_IRQ_STAT: rd_val = {28'h0000000, irq_stat};
            `CBT_ADDR_IRQ_MASK: rd_val = {28'h0000000, irq_mask};
            default: begin
                rd_val = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h00000000;
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdog_limit <= `CBT_WDOG_RESET;
            irq_mask <= `CBT_IRQ_MASK_RESET;
        end else if (wr_en && paddr == `CBT_ADDR_WDOG) begin
            wdog_limit <= pwdata[7:0];
        end else if (wr_en && paddr == `CBT_ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_stat <= 4'h0;
            test_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            test_q <= test_mode;
            irq_stat <= (irq_stat & ~((wr_en && paddr == `CBT_ADDR_IRQ_STAT) ? pwdata[3:0] : 4'h0)) | events;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_test_entry: assert property (@(posedge clock) disable iff (!rst_n)
        tri_decode(style_pin) == CBT_LVL_MID |=> test_mode) else $error("middle style did not select test mode");
    chk_bypass_src: assert property (@(posedge clock) disable iff (!rst_n)
        test_mode && !held[0] |=> bank1_outputs.q[0] == $past(ref_lvl)) else $error("PLL not bypassed");
    chk_disable_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        test_mode && !treset |=> bank1_outputs.oe == 4'hF) else $error("bank disabled in test mode");
    chk_treset_hiz: assert property (@(posedge clock) disable iff (!rst_n)
        test_mode && dis[1] && state == CBT_ST_RUN |=> ##1 !bank2_outputs.oe[0] && !feedback_bank_oe[0])
        else $error("outputs not high impedance in test reset");
    chk_five_edges: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(force_fsm) |-> $past(ref_rise) && $past(edge_cnt) == `CBT_TRESET_LAST)
        else $error("test reset did not wait five reference edges");
    chk_hold_seed: assert property (@(posedge clock) disable iff (!rst_n)
        force_fsm |=> fb_cnt == $past(cfg.ratio) - 4'h1 && !locked) else $error("reset state wrong");
    chk_hold_release: assert property (@(posedge clock) disable iff (!rst_n)
        state == CBT_ST_HOLD && dis[1] |=> state == CBT_ST_HOLD) else $error("left hold early");
    chk_lock_out: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 lock_indicator == $past(locked)) else $error("lock output mismatch");
    chk_hiz_style: assert property (@(posedge clock) disable iff (!rst_n)
        !treset && bank_off[0] && hiz_style |=> bank1_outputs.oe == 4'h0)
        else $error("disabled bank not high impedance");
    chk_gain_count: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(locked) |-> $past(good_run) == `CBT_GAIN_LAST) else $error("lock gained early");

endmodule // cbt_top
